// ### hw/cfg_regs_pkg.sv
// Purpose: Shared constants and carriers for the configuration header registers.
// Assumes: Offsets are byte addresses of aligned 32-bit words.
// Notes:   Write masks mark the bits that configuration software may change.
package cfg_regs_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFF_LAT = 8'h0c;
  localparam logic [7:0] OFF_IO  = 8'h10;
  localparam logic [7:0] OFF_MEM = 8'h14;
  localparam logic [7:0] OFF_SID = 8'h2c;

  // Values after hard reset.
  localparam logic [31:0] RST_LAT = 32'h0000_0000;
  localparam logic [31:0] RST_IO  = 32'h0000_0001;
  localparam logic [31:0] RST_MEM = 32'h0000_0000;
  localparam logic [31:0] RST_SID = 32'h1d2e_3c4b; // Identification value is arbitrary.

  // Writable bits and read-only ones of each register.
  localparam logic [31:0] WMASK_LAT = 32'h0000_ffff;
  localparam logic [31:0] WMASK_IO  = 32'hffff_ff00;
  localparam logic [31:0] WMASK_MEM = 32'hffff_f000;
  localparam logic [31:0] RO1_IO    = 32'h0000_0001;

  // Field positions.
  localparam int TENURE_LSB = 8;
  localparam int CLS_LSB    = 0;
  localparam int IO_LSB     = 8;
  localparam int MEM_LSB    = 12;

  // Bus-master command codes.
  localparam logic [3:0] CMD_MEM_READ  = 4'h6;
  localparam logic [3:0] CMD_MEM_WRITE = 4'h7;

  // Tenure counter start value.
  localparam logic [7:0] TENURE_CNT_RST = 8'h00;

  // Configuration access request.
  typedef struct packed {
    logic        we;
    logic [7:0]  offset;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfg_req_s;

  // Subsystem identification load from the serial EEPROM path.
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } id_load_s;

  // Bus-master sequencer states, Gray coded along idle, active, expired.
  typedef enum logic [1:0] {
    MST_IDLE    = 2'b00,
    MST_ACTIVE  = 2'b01,
    MST_EXPIRED = 2'b11
  } mst_state_e;

endpackage

// ### hw/cfg_id_store.sv
// Purpose: Holds the subsystem identification word.
// Assumes: Load data arrive synchronous to the clock.
// Notes:   Read data come straight from the stored register.
`timescale 1ns/100ps
module cfg_id_store (
  // Clock and reset.
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // Load path.
  input  wire logic                     load_enable,
  input  wire cfg_regs_pkg::id_load_s   load,
  // Stored word.
  output logic [31:0]                   id_q
);

  // The word changes only by an enabled load, never by a configuration write.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      id_q <= cfg_regs_pkg::RST_SID;
    end else if (load_enable && load.valid) begin
      id_q <= load.data;
    end
  end

endmodule

// ### hw/pci_config_header_regs.sv
// Purpose: Latency, base address and subsystem identification configuration registers,
//          target address decode and bus-master command and tenure control.
// Assumes: All inputs but reset_n are synchronous to ref_clk; command register bits arrive as inputs.
// Notes:   Soft reset leaves every configuration register unchanged; only soft_reset_seen_q follows it.
// Function
// - Self-test capable bit 31 of the latency register reads zero.
// - Self-test enable bit 30 and bits 29-16 read zero, ignore writes.
// - Bits 15-8 hold tenure clocks; reaching it raises tenure_expired_q, but ownership ends only on mst_done.
// - Cache line size bits 7-0 are stored but never steer master transfers.
// - Master reads use command 0110, master writes use 0111.
// - I/O register bits 7-2 read zero, asking for 256 bytes.
// - I/O register bit 1 reads zero, bit 0 reads one.
// - Memory register bits 11-4 read zero, asking for 4096 bytes.
// - Memory prefetch bit 3 and placement bits 2-1 read zero.
// - Memory register bit 0 reads zero.
// - Subsystem codes read only, reset to a fixed code, loaded from EEPROM when enabled.
// - I/O accesses are claimed only while I/O decode is enabled.
// - Memory accesses are claimed only while memory decode is enabled.
// - Master transfers start only while master enable is set.
`timescale 1ns/100ps
module pci_config_header_regs (
  // Clock and reset.
  input  wire logic                     ref_clk,
  input  wire logic                     reset_n,
  input  wire logic                     soft_reset,
  // Configuration access.
  input  wire logic                     cfg_req,
  input  wire cfg_regs_pkg::cfg_req_s   cfg,
  output logic                          cfg_ack_q,
  output logic [31:0]                   cfg_rdata_q,
  // Command register bits.
  input  wire logic                     io_decode_enable,
  input  wire logic                     mem_decode_enable,
  input  wire logic                     master_enable,
  // EEPROM load path.
  input  wire logic                     cfg_load_enable,
  input  wire cfg_regs_pkg::id_load_s   id_load,
  // Target address decode.
  input  wire logic                     tgt_valid,
  input  wire logic                     tgt_is_io,
  input  wire logic [31:0]              tgt_addr,
  output logic                          io_hit_q,
  output logic                          mem_hit_q,
  // Bus-master control.
  input  wire logic                     mst_req,
  input  wire logic                     mst_write,
  input  wire logic                     mst_done,
  output logic                          mst_start_q,
  output logic [3:0]                    mst_cmd_q,
  output logic                          mst_active_q,
  output logic                          tenure_expired_q
);

  logic [1:0]               rst_sync_q;
  logic                     rst_n;
  logic [31:0]              lat_q;
  logic [31:0]              io_q;
  logic [31:0]              mem_q;
  logic [31:0]              sid_q;
  logic [7:0]               tenure_cnt_q;
  cfg_regs_pkg::mst_state_e mst_state_q;
  logic                     wr_lat;
  logic                     wr_io;
  logic                     wr_mem;
  logic [7:0]               tenure_limit;
  logic [7:0]               cfg_wbyte0;
  logic                     soft_reset_seen_q;

  // Merge write data into a register under byte enables and a writable mask.
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be, input logic [31:0] wmask);
    logic [31:0] lanes;
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    return (old & ~lanes) | (wd & lanes);
  endfunction

  // Reset release through two flip-flops.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Write strobes per register.
  assign wr_lat = cfg_req && cfg.we && (cfg.offset == cfg_regs_pkg::OFF_LAT);
  assign wr_io  = cfg_req && cfg.we && (cfg.offset == cfg_regs_pkg::OFF_IO);
  assign wr_mem = cfg_req && cfg.we && (cfg.offset == cfg_regs_pkg::OFF_MEM);
  assign tenure_limit = lat_q[cfg_regs_pkg::TENURE_LSB +: 8];
  assign cfg_wbyte0   = cfg.wdata[7:0];

  // Latency register keeps only the tenure and cache line fields.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lat_q <= cfg_regs_pkg::RST_LAT;
    end else if (wr_lat) begin
      lat_q <= be_merge(lat_q, cfg.wdata, cfg.be, cfg_regs_pkg::WMASK_LAT);
    end
  end

  // I/O base register; size bits stay zero and the space indicator stays one.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_q <= cfg_regs_pkg::RST_IO;
    end else if (wr_io) begin
      io_q <= be_merge(io_q, cfg.wdata, cfg.be, cfg_regs_pkg::WMASK_IO)
              | cfg_regs_pkg::RO1_IO;
    end
  end

  // Memory base register; size, prefetch, placement and indicator bits stay zero.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_q <= cfg_regs_pkg::RST_MEM;
    end else if (wr_mem) begin
      mem_q <= be_merge(mem_q, cfg.wdata, cfg.be, cfg_regs_pkg::WMASK_MEM);
    end
  end

  // Subsystem identification store.
  cfg_id_store u_id_store (
    .clk         (ref_clk),
    .rst_n       (rst_n),
    .load_enable (cfg_load_enable),
    .load        (id_load),
    .id_q        (sid_q)
  );

  // Soft reset is noted in soft_reset_seen_q but deliberately alters no configuration register.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_reset_seen_q <= 1'b0;
    end else begin
      soft_reset_seen_q <= soft_reset;
    end
  end

  // Read data and acknowledge one cycle after a request; unmapped offsets read zero.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ack_q   <= 1'b0;
      cfg_rdata_q <= 32'h0000_0000;
    end else begin
      cfg_ack_q <= cfg_req;
      if (cfg_req && !cfg.we) begin
        case (cfg.offset)
          cfg_regs_pkg::OFF_LAT: cfg_rdata_q <= lat_q & cfg_regs_pkg::WMASK_LAT;
          cfg_regs_pkg::OFF_IO:  cfg_rdata_q <= io_q;
          cfg_regs_pkg::OFF_MEM: cfg_rdata_q <= mem_q;
          cfg_regs_pkg::OFF_SID: cfg_rdata_q <= sid_q;
          default:               cfg_rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Target decode against the programmed base bits, gated by the space enables.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_hit_q  <= 1'b0;
      mem_hit_q <= 1'b0;
    end else begin
      io_hit_q  <= tgt_valid && tgt_is_io && io_decode_enable
                   && (tgt_addr[31:cfg_regs_pkg::IO_LSB] == io_q[31:cfg_regs_pkg::IO_LSB]);
      mem_hit_q <= tgt_valid && !tgt_is_io && mem_decode_enable
                   && (tgt_addr[31:cfg_regs_pkg::MEM_LSB] == mem_q[31:cfg_regs_pkg::MEM_LSB]);
    end
  end

  // Master sequencer: start, count tenure clocks, flag expiry, end on done.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mst_state_q      <= cfg_regs_pkg::MST_IDLE;
      tenure_cnt_q     <= cfg_regs_pkg::TENURE_CNT_RST;
      mst_start_q      <= 1'b0;
      mst_cmd_q        <= cfg_regs_pkg::CMD_MEM_READ;
      mst_active_q     <= 1'b0;
      tenure_expired_q <= 1'b0;
    end else begin
      mst_start_q <= 1'b0;
      case (mst_state_q)
        cfg_regs_pkg::MST_IDLE: begin
          if (mst_req && master_enable) begin
            mst_state_q  <= cfg_regs_pkg::MST_ACTIVE;
            mst_start_q  <= 1'b1;
            mst_active_q <= 1'b1;
            tenure_cnt_q <= cfg_regs_pkg::TENURE_CNT_RST;
            mst_cmd_q    <= mst_write ? cfg_regs_pkg::CMD_MEM_WRITE
                                      : cfg_regs_pkg::CMD_MEM_READ;
          end
        end
        cfg_regs_pkg::MST_ACTIVE: begin
          if (mst_done) begin
            mst_state_q  <= cfg_regs_pkg::MST_IDLE;
            mst_active_q <= 1'b0;
          end else if (tenure_cnt_q == tenure_limit) begin
            mst_state_q      <= cfg_regs_pkg::MST_EXPIRED;
            tenure_expired_q <= 1'b1;
          end else begin
            tenure_cnt_q <= tenure_cnt_q + 8'h01;
          end
        end
        cfg_regs_pkg::MST_EXPIRED: begin
          if (mst_done) begin
            mst_state_q      <= cfg_regs_pkg::MST_IDLE;
            mst_active_q     <= 1'b0;
            tenure_expired_q <= 1'b0;
          end
        end
        default: begin
          mst_state_q      <= cfg_regs_pkg::MST_IDLE;
          mst_active_q     <= 1'b0;
          tenure_expired_q <= 1'b0;
        end
      endcase
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_rd_lat;
    cfg_req && !cfg.we && (cfg.offset == cfg_regs_pkg::OFF_LAT);
  endsequence
  sequence s_rd_io;
    cfg_req && !cfg.we && (cfg.offset == cfg_regs_pkg::OFF_IO);
  endsequence
  sequence s_rd_mem;
    cfg_req && !cfg.we && (cfg.offset == cfg_regs_pkg::OFF_MEM);
  endsequence
  sequence s_wr_cls;
    wr_lat && cfg.be[0];
  endsequence

  chk_selftest_cap_zero: assert property (s_rd_lat |=> cfg_rdata_q[31] == 1'b0)
    else $error("self-test capable bit read nonzero");
  chk_lat_upper_zero: assert property (s_rd_lat |=> cfg_rdata_q[30:16] == 15'h0000)
    else $error("latency register upper bits read nonzero");
  chk_tenure_expiry: assert property ($rose(tenure_expired_q) |->
                                      $past(tenure_cnt_q) == $past(tenure_limit))
    else $error("tenure expired at wrong count");
  chk_cls_stored: assert property (s_wr_cls |=> lat_q[7:0] == $past(cfg_wbyte0))
    else $error("cache line size not stored");
  chk_master_cmd: assert property (mst_start_q |-> mst_cmd_q ==
      ($past(mst_write) ? cfg_regs_pkg::CMD_MEM_WRITE : cfg_regs_pkg::CMD_MEM_READ))
    else $error("wrong master command code");
  chk_io_low_bits: assert property (s_rd_io |=> cfg_rdata_q[7:0] == 8'h01)
    else $error("I/O base low bits wrong");
  chk_mem_low_bits: assert property (s_rd_mem |=> cfg_rdata_q[11:0] == 12'h000)
    else $error("memory base low bits wrong");
  chk_sid_read: assert property (cfg_req && !cfg.we && (cfg.offset == cfg_regs_pkg::OFF_SID)
                                 |=> cfg_rdata_q == $past(sid_q))
    else $error("subsystem identification read wrong");
  chk_io_gate: assert property (io_hit_q |-> $past(io_decode_enable))
    else $error("I/O hit while I/O decode disabled");
  chk_mem_gate: assert property (mem_hit_q |-> $past(mem_decode_enable))
    else $error("memory hit while memory decode disabled");
  chk_master_gate: assert property (mst_start_q |-> $past(master_enable))
    else $error("master start while master disabled");
  chk_io_match: assert property (tgt_valid && tgt_is_io && io_decode_enable &&
      (tgt_addr[31:8] == io_q[31:8]) |=> io_hit_q)
    else $error("matching I/O access not claimed");

endmodule

// ### test/cfg_host_model.sv
// Purpose: Host model that issues configuration accesses to the register block.
// Assumes: One access per call; the strobe lasts one cycle and the answer stands the next cycle.
// Notes:   Once released, the write data lines carry the inverse of the last word.
`timescale 1ns/100ps
module cfg_host_model (
  // Clock and answer.
  input  wire logic                   ref_clk,
  input  wire logic                   cfg_ack_q,
  input  wire logic [31:0]            cfg_rdata_q,
  // Request.
  output logic                        cfg_req,
  output cfg_regs_pkg::cfg_req_s      cfg
);
  // Idle request lines at time zero.
  initial begin
    cfg_req = 1'b0;
    cfg     = '0;
  end

  // Software places window bases and reads words back; each access ends at its answer.
  task automatic xfer(input logic we, input logic [7:0] off, input logic [3:0] be,
                      input logic [31:0] wd, output logic [31:0] rd, output logic ok);
    @(posedge ref_clk);
    #5;
    cfg_req = 1'b1;
    cfg     = '{we: we, offset: off, be: be, wdata: wd};
    @(posedge ref_clk);
    #5;
    cfg_req   = 1'b0;
    cfg.wdata = ~wd;
    // The answer was launched at the edge that took the request and stands until the next one.
    ok = cfg_ack_q;
    rd = cfg_rdata_q;
  endtask
endmodule

// ### test/pci_config_header_regs_bench.sv
// Purpose: Self-checking bench for the configuration header registers.
// Assumes: Inputs change 5 ns after the rising edge; outputs are read 1 ns or 5 ns after it.
// Notes:   Random values come from a fixed-seed shift register.
`timescale 1ns/100ps
module pci_config_header_regs_bench;
  logic                    ref_clk, reset_n, soft_reset, cfg_req, cfg_ack_q, cfg_load_enable;
  logic                    io_decode_enable, mem_decode_enable, master_enable;
  logic                    tgt_valid, tgt_is_io, io_hit_q, mem_hit_q;
  logic                    mst_req, mst_write, mst_done, mst_start_q, mst_active_q;
  logic                    tenure_expired_q;
  logic [3:0]              mst_cmd_q;
  logic [31:0]             cfg_rdata_q, tgt_addr, r;
  cfg_regs_pkg::cfg_req_s  cfg;
  cfg_regs_pkg::id_load_s  id_load;
  logic [31:0]             lfsr = 32'h7ef5;
  logic [31:0]             sh [4];
  logic [7:0]              offs [4] = '{8'h0c, 8'h10, 8'h14, 8'h2c};
  logic [31:0]             msk [4] = '{32'h0000_ffff, 32'hffff_ff00, 32'hffff_f000, 32'h0};
  int                      error_cnt = 0;
  int                      check_count = 0;

  // Device under test and host partner.
  pci_config_header_regs pci_config_header_regs_inst (
    .ref_clk           (ref_clk),
    .reset_n           (reset_n),
    .soft_reset        (soft_reset),
    .cfg_req           (cfg_req),
    .cfg               (cfg),
    .cfg_ack_q         (cfg_ack_q),
    .cfg_rdata_q       (cfg_rdata_q),
    .io_decode_enable  (io_decode_enable),
    .mem_decode_enable (mem_decode_enable),
    .master_enable     (master_enable),
    .cfg_load_enable   (cfg_load_enable),
    .id_load           (id_load),
    .tgt_valid         (tgt_valid),
    .tgt_is_io         (tgt_is_io),
    .tgt_addr          (tgt_addr),
    .io_hit_q          (io_hit_q),
    .mem_hit_q         (mem_hit_q),
    .mst_req           (mst_req),
    .mst_write         (mst_write),
    .mst_done          (mst_done),
    .mst_start_q       (mst_start_q),
    .mst_cmd_q         (mst_cmd_q),
    .mst_active_q      (mst_active_q),
    .tenure_expired_q  (tenure_expired_q)
  );
  cfg_host_model cfg_host_model_inst (.ref_clk(ref_clk), .cfg_ack_q(cfg_ack_q),
    .cfg_rdata_q(cfg_rdata_q), .cfg_req(cfg_req), .cfg(cfg));

  // Free-running 20 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Watchdog well beyond the expected run of under a thousand cycles.
  initial begin
    #250000;
    error_cnt++;
    report_and_stop();
  end

  // Next value of the random sequence.
  function automatic logic [31:0] nxt();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  // Expected register after a write: only enabled writable bytes change.
  function automatic logic [31:0] expect_reg(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [31:0] m, input logic [3:0] be);
    logic [31:0] bm;
    for (int i = 0; i < 4; i++) bm[8*i+:8] = {8{be[i]}};
    return (old & ~(m & bm)) | (wd & m & bm);
  endfunction

  // Counts a comparison and reports a mismatch.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Read one word and compare it.
  task automatic rd(input logic [7:0] off, input logic [31:0] e);
    logic [31:0] v;
    logic        ok;
    cfg_host_model_inst.xfer(1'b0, off, 4'hf, nxt(), v, ok);
    chk("read ack", 32'h1, ok);
    chk("read data", e, v);
  endtask

  // Write one word and track the expected content.
  task automatic wr(input int k, input logic [3:0] be, input logic [31:0] wd);
    logic [31:0] v;
    logic        ok;
    cfg_host_model_inst.xfer(1'b1, offs[k], be, wd, v, ok);
    chk("write ack", 32'h1, ok);
    sh[k] = expect_reg(sh[k], wd, msk[k], be);
  endtask

  // One target access in either space, matching or not, with its decode enable set or not.
  task automatic tgt(input logic io, input logic m, input logic en);
    r = nxt();
    r = io ? {sh[1][31:8], r[7:0]} : {sh[2][31:12], r[11:0]};
    r[31] = m ? r[31] : ~r[31];
    @(posedge ref_clk);
    #5;
    io_decode_enable  = io ? en : ~en;
    mem_decode_enable = io ? ~en : en;
    tgt_valid = 1'b1;
    tgt_is_io = io;
    tgt_addr  = r;
    @(posedge ref_clk);
    #5;
    tgt_valid = 1'b0;
    tgt_addr  = ~r;
    // The hit pulse stands from the taking edge to the next one.
    chk("io_hit_q", io & m & en, io_hit_q);
    chk("mem_hit_q", !io & m & en, mem_hit_q);
  endtask

  // One master transfer with a given tenure limit and a random cache line size.
  task automatic mst(input logic w, input logic [7:0] lim, input logic en);
    r = nxt();
    wr(0, 4'hf, {r[31:16], lim, r[7:0]});
    @(posedge ref_clk);
    #5;
    master_enable = en;
    mst_write     = w;
    mst_req       = 1'b1;
    @(posedge ref_clk);
    #5;
    mst_req = 1'b0;
    // The start pulse stands only in the cycle after the taking edge.
    chk("mst_start_q", en, mst_start_q);
    if (en) chk("mst_cmd_q", w ? 32'h7 : 32'h6, mst_cmd_q);
    for (int j = 0; j <= lim; j++) begin
      chk("tenure early", 32'h0, tenure_expired_q);
      chk("mst_active_q", en, mst_active_q);
      @(posedge ref_clk);
      #1;
    end
    chk("tenure end", en, tenure_expired_q);
    #4 mst_done = 1'b1;
    @(posedge ref_clk);
    #1;
    chk("active after done", 32'h0, mst_active_q);
    #4 mst_done = 1'b0;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    {reset_n, soft_reset, cfg_load_enable, io_decode_enable, mem_decode_enable} = '0;
    {master_enable, tgt_valid, tgt_is_io, mst_req, mst_write, mst_done} = '0;
    tgt_addr = '0;
    id_load  = '0;
    repeat (2) @(posedge ref_clk);
    #5 reset_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    sh = '{32'h0, 32'h1, 32'h0, cfg_regs_pkg::RST_SID};
    for (int k = 0; k < 4; k++) rd(offs[k], sh[k]);
    rd(8'h00, 32'h0);
    // All-ones words first, then random words and byte enables; each is read back.
    for (int n = 0; n < 24; n++) begin
      r = nxt();
      wr(n % 4, n < 4 ? 4'hf : r[3:0], n < 4 ? 32'hffff_ffff : nxt());
      rd(offs[n % 4], sh[n % 4] | {31'h0, n % 4 == 1});
    end
    // Soft reset must leave the latency, I/O and memory registers as they were.
    soft_reset = 1'b1;
    for (int k = 0; k < 3; k++) rd(offs[k], sh[k] | {31'h0, k == 1});
    soft_reset = 1'b0;
    // Identification loads only while loading is enabled.
    for (int e = 0; e < 2; e++) begin
      r = nxt();
      @(posedge ref_clk);
      #5;
      cfg_load_enable = e[0];
      id_load = '{valid: 1'b1, data: r};
      @(posedge ref_clk);
      #5;
      id_load.valid = 1'b0;
      if (e == 1) sh[3] = r;
      rd(8'h2c, sh[3]);
    end
    wr(1, 4'hf, nxt());
    wr(2, 4'hf, nxt());
    for (int n = 0; n < 24; n++) begin
      r = nxt();
      tgt(r[0], r[1] | (n < 4), r[2] | (n < 2));
    end
    mst(1'b0, 8'h00, 1'b1);
    mst(1'b1, 8'h05, 1'b1);
    mst(1'b1, 8'h02, 1'b0);
    for (int n = 0; n < 4; n++) mst(n[0], 8'(nxt() % 8), 1'b1);
    report_and_stop();
  end
endmodule
